/* File: design/pmsr_smbus_slave.sv */
/*
  pmsr_smbus_slave: serial command front end of a rail power monitor.
  holds the configuration word and returns the output register.
  assumes: open-drain bus with external pull-ups; scl never driven here.
  assumes: core clock at least eight times the bus bit rate, so every
  bus phase spans several core cycles after the two-flop synchronisers.
  assumes: the measurement engine holds meas_busy for a whole run and
  pulses meas_done once, with meas_count valid in that cycle.
*/
//
// Contract
// - result saturates at plus and minus 256
// - count in bits 15:6, six zero pad
// - binary point sits above six low bits
// - one output register for all quantities
// - three read commands return same register
// - config write: addr, command, low, high
// - config read: repeated start, low then high
// - ack low, nack high, read bit one
// - voltage read command returns output register
// - current read command returns output register
// - power read command returns output register
// - config bits 7:6 select output quantity
// - configuration word lives at command D0h
// - selection change waits for running measurement
`timescale 1ns/1ps
module pmsr_smbus_slave
  import pmsr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,  // arbitrary default
  parameter int         COUNT_W    = 10
)(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // serial bus pins
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // measurement engine
  input  wire logic               meas_busy,
  input  wire logic               meas_done,
  input  wire logic signed [COUNT_W-1:0] meas_count,
  output logic      [1:0]         meas_sel,
  // configuration word
  output logic      [15:0]        cfg_word
);
  if (COUNT_W < PMSR_CNT_BITS) begin : g_chk
    $error("pmsr_smbus_slave: COUNT_W too small");
  end

  pmsr_line_if line ();          // conditioned bus events

  // sequencer position and bit count
  pmsr_state_t state_r;          // protocol position
  logic [3:0]  bit_cnt_r;        // bits of current byte

  // shifters and held bytes
  logic [7:0]  rx_sh_r;          // receive shifter
  logic [7:0]  tx_sh_r;          // transmit shifter
  logic [7:0]  cmd_r;            // last command code
  logic [7:0]  wlow_r;           // low data byte held

  // direction and pairing flags
  logic        byte_hi_r;        // second byte of pair
  logic        rd_r;             // read direction taken
  logic        mack_r;           // host acked our byte

  // register contents
  logic [15:0] cfg_r;            // configuration word
  logic [15:0] result;           // output register
  logic [1:0]  sel_act;          // applied selection
  logic [15:0] rd_word;          // word to return

  // byte-complete strobes
  logic        byte_end;         // closing fall of a full byte
  logic        cmd_end;          // command byte complete
  logic        wlow_end;         // low data byte complete
  logic        whigh_end;        // high data byte complete

  // bus pin conditioning
  // pins pass two flops before any logic here reads them
  pmsr_line_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .line   (line.src)
  );

  // output register and selection handover
  // the engine sees a new selection only between runs
  pmsr_result_reg #(.COUNT_W(COUNT_W)) u_res (
    .clk        (clk),
    .rst_n      (rst_n),
    .sel_cfg    (cfg_r[PMSR_SEL_MSB:PMSR_SEL_LSB]),
    .sel_act    (sel_act),
    .meas_busy  (meas_busy),
    .meas_done  (meas_done),
    .meas_count (meas_count),
    .result     (result)
  );

  // a read command is one of the three measurement reads
  function automatic logic is_meas_rd(input logic [7:0] c);
    is_meas_rd = (c == PMSR_CMD_VOUT) ||
                 (c == PMSR_CMD_IOUT) ||
                 (c == PMSR_CMD_POUT);
  endfunction

  // a full byte has been shifted in or out
  function automatic logic byte_full(input logic [3:0] n);
    byte_full = (n == PMSR_BYTE_BITS);
  endfunction

  // word returned by a read, selected by command
  always_comb begin
    if (cmd_r == PMSR_CMD_CFG) begin
      rd_word = cfg_r;
    end else if (is_meas_rd(cmd_r)) begin
      rd_word = result;
    end else begin
      rd_word = PMSR_NO_DATA;      // unknown and reserved codes
    end
  end

  // protocol sequencer
  // stop outranks start and both outrank clock edges, so a condition
  // seen in the cycle of an edge always resets the byte framing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= PMSR_IDLE;
      bit_cnt_r <= 4'h0;
      rx_sh_r   <= 8'h00;
      tx_sh_r   <= 8'h00;
      byte_hi_r <= 1'b0;
      rd_r      <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (line.stop_det) begin
      // stop ends anything and frees the line
      state_r <= PMSR_IDLE;
      sda_oe  <= 1'b0;
    end else if (line.start_det) begin
      // start or repeated start, command code kept
      state_r   <= PMSR_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (line.scl_rise) begin
      // sampling edge: bits are taken while the clock is high
      case (state_r)
        // shift receive bits, msb first
        PMSR_ADDR, PMSR_CMD, PMSR_WDATA: begin
          rx_sh_r   <= {rx_sh_r[6:0], line.sda_lvl};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        // count bits sampled by the host
        PMSR_TX: bit_cnt_r <= bit_cnt_r + 4'h1;
        // host answer: low is ack, high is nack
        PMSR_TX_ACK: mack_r <= ~line.sda_lvl;
        default: ;
      endcase
    end else if (line.scl_fall) begin
      // driving edge: the data line may change only while clock is low
      case (state_r)
        // address byte complete
        PMSR_ADDR: begin
          if (bit_cnt_r == PMSR_BYTE_BITS) begin
            if (rx_sh_r[7:1] == SLAVE_ADDR) begin
              rd_r    <= rx_sh_r[0];
              sda_oe  <= 1'b1;        // ack drives low
              state_r <= PMSR_ADDR_ACK;
            end else begin
              state_r <= PMSR_WAIT;   // not ours
            end
          end
        end
        // end of address ack
        PMSR_ADDR_ACK: begin
          bit_cnt_r <= 4'h0;
          byte_hi_r <= 1'b0;
          if (rd_r) begin
            // low byte first
            tx_sh_r <= rd_word[7:0];
            sda_oe  <= ~rd_word[7];
            state_r <= PMSR_TX;
          end else begin
            sda_oe  <= 1'b0;
            state_r <= PMSR_CMD;
          end
        end
        // command byte complete
        PMSR_CMD: begin
          if (bit_cnt_r == PMSR_BYTE_BITS) begin
            sda_oe  <= 1'b1;
            state_r <= PMSR_CMD_ACK;
          end
        end
        // end of command ack, first data byte next
        PMSR_CMD_ACK: begin
          sda_oe    <= 1'b0;
          bit_cnt_r <= 4'h0;
          state_r   <= PMSR_WDATA;
        end
        // data byte complete
        PMSR_WDATA: begin
          if (bit_cnt_r == PMSR_BYTE_BITS) begin
            sda_oe  <= 1'b1;
            state_r <= PMSR_WDATA_ACK;
          end
        end
        // low byte then high byte
        PMSR_WDATA_ACK: begin
          sda_oe    <= 1'b0;
          bit_cnt_r <= 4'h0;
          byte_hi_r <= ~byte_hi_r;
          state_r   <= byte_hi_r ? PMSR_WAIT : PMSR_WDATA;
        end
        // shift out, release after eighth bit for host ack
        PMSR_TX: begin
          if (bit_cnt_r == PMSR_BYTE_BITS) begin
            sda_oe  <= 1'b0;
            state_r <= PMSR_TX_ACK;
          end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            sda_oe  <= ~tx_sh_r[6];
          end
        end
        // host acked low byte: send high; else stop sending
        PMSR_TX_ACK: begin
          bit_cnt_r <= 4'h0;
          if (mack_r && !byte_hi_r) begin
            byte_hi_r <= 1'b1;
            tx_sh_r   <= rd_word[15:8];
            sda_oe    <= ~rd_word[15];
            state_r   <= PMSR_TX;
          end else begin
            state_r <= PMSR_WAIT;  // nack ends read
          end
        end
        default: ;
      endcase
    end
  end

  // closing fall of a received byte, by where the sequencer stands
  assign byte_end  = line.scl_fall && byte_full(bit_cnt_r);
  assign cmd_end   = byte_end && (state_r == PMSR_CMD);
  assign wlow_end  = byte_end && (state_r == PMSR_WDATA) && !byte_hi_r;
  assign whigh_end = byte_end && (state_r == PMSR_WDATA) && byte_hi_r;

  // command code capture, kept across a repeated start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;              // no command seen yet
    end else if (cmd_end) begin
      cmd_r <= rx_sh_r;
    end
  end

  // low data byte held until the high byte arrives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wlow_r <= 8'h00;             // nothing held
    end else if (wlow_end) begin
      wlow_r <= rx_sh_r;
    end
  end

  // configuration word commits on the high byte only: a lone low
  // byte cut short by a stop never leaves a half-written word;
  // other codes, the reserved ones too, leave the word untouched
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= PMSR_CFG_RESET;     // start-up configuration
    end else if (whigh_end && (cmd_r == PMSR_CMD_CFG)) begin
      cfg_r <= {rx_sh_r, wlow_r};
    end
  end

  // data pin value: open drain, only low is ever driven
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;             // low drive value after reset
    end else begin
      sda_out <= 1'b0;             // pull-up makes the high level
    end
  end

  // applied selection to the engine, one stage after the handover
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meas_sel <= PMSR_SEL_POWER;
    end else begin
      meas_sel <= sel_act;
    end
  end

  // configuration word mirrored to the rest of the device
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_word <= PMSR_CFG_RESET;  // start-up field values
    end else begin
      cfg_word <= cfg_r;           // follows a committed bus write
    end
  end
endmodule // pmsr_smbus_slave

/* File: include/pmsr_pkg.sv */
/*
  pmsr_pkg: constants shared by the power monitor serial readout.
  assumes: included before the line interface and the design modules.
*/
package pmsr_pkg;
  // command codes
  localparam logic [7:0]  PMSR_CMD_CFG   = 8'hd0;  // configuration word
  localparam logic [7:0]  PMSR_CMD_VOUT  = 8'h8b;  // voltage read
  localparam logic [7:0]  PMSR_CMD_IOUT  = 8'h8c;  // current read
  localparam logic [7:0]  PMSR_CMD_POUT  = 8'h96;  // power read
  // output selection codes, config bits 7:6
  localparam logic [1:0]  PMSR_SEL_POWER = 2'h0;
  localparam logic [1:0]  PMSR_SEL_VOLT  = 2'h1;
  localparam logic [1:0]  PMSR_SEL_CURR  = 2'h2;
  localparam int          PMSR_SEL_LSB   = 6;
  localparam int          PMSR_SEL_MSB   = 7;
  // result word layout
  localparam int          PMSR_PAD_BITS  = 6;       // zero padding below the point
  localparam int          PMSR_CNT_BITS  = 10;      // sign plus nine count bits
  localparam logic signed [9:0] PMSR_FS_POS = 10'sh100;  // +256 counts
  localparam logic signed [9:0] PMSR_FS_NEG = -10'sh100; // -256 counts
  // reset values
  localparam logic [15:0] PMSR_CFG_RESET = 16'h0000;
  localparam logic [15:0] PMSR_RES_RESET = 16'h0000;
  localparam logic [15:0] PMSR_NO_DATA   = 16'hffff;  // unknown command read
  // framing
  localparam logic [3:0]  PMSR_BYTE_BITS = 4'h8;
  // protocol states
  typedef enum logic [3:0] {
    PMSR_IDLE, PMSR_ADDR, PMSR_ADDR_ACK, PMSR_CMD, PMSR_CMD_ACK,
    PMSR_WDATA, PMSR_WDATA_ACK, PMSR_TX, PMSR_TX_ACK, PMSR_WAIT
  } pmsr_state_t;
endpackage

/* File: include/pmsr_line_if.sv */
/*
  pmsr_line_if: conditioned bus events from the synchroniser to the engine.
  assumes: all signals on the core clock, events one cycle wide.
*/
`timescale 1ns/1ps
interface pmsr_line_if;
  logic scl_rise;   // clock line went high
  logic scl_fall;   // clock line went low
  logic start_det;  // start or repeated start
  logic stop_det;   // stop condition
  logic sda_lvl;    // synchronised data level
  modport src (output scl_rise, output scl_fall, output start_det, output stop_det,
               output sda_lvl);
  modport dst (input scl_rise, input scl_fall, input start_det, input stop_det,
               input sda_lvl);
endinterface

/* File: design/pmsr_line_sync.sv */
/*
  pmsr_line_sync: two-flop synchronisers and edge/condition detection of the bus pins.
  assumes: pins asynchronous to clk; clk far faster than the bus clock.
*/
`timescale 1ns/1ps
module pmsr_line_sync
  import pmsr_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // conditioned events
  pmsr_line_if.src  line
);
  logic [1:0] scl_sy_r;  // scl synchroniser
  logic [1:0] sda_sy_r;  // sda synchroniser
  logic       scl_d_r;   // delayed scl for edges
  logic       sda_d_r;   // delayed sda for edges

  // synchronisers, idle bus is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
    end else begin
      scl_sy_r <= {scl_sy_r[0], scl_in};
      sda_sy_r <= {sda_sy_r[0], sda_in};
    end
  end

  // delay stage after the synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_sy_r[1];
      sda_d_r <= sda_sy_r[1];
    end
  end

  // event decode from second stage and delay stage only
  assign line.scl_rise  = scl_sy_r[1] & ~scl_d_r;
  assign line.scl_fall  = ~scl_sy_r[1] & scl_d_r;
  assign line.start_det = scl_sy_r[1] & scl_d_r & ~sda_sy_r[1] & sda_d_r;
  assign line.stop_det  = scl_sy_r[1] & scl_d_r & sda_sy_r[1] & ~sda_d_r;
  assign line.sda_lvl   = sda_sy_r[1];
endmodule // pmsr_line_sync

/* File: design/pmsr_result_reg.sv */
/*
  pmsr_result_reg: the single output register and the selection it reports.
  assumes: measurement engine gives a signed count with a done pulse and busy level.
*/
`timescale 1ns/1ps
module pmsr_result_reg
  import pmsr_pkg::*;
#(
  parameter int COUNT_W = 10
)(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // configured and applied selection
  input  wire logic [1:0]         sel_cfg,
  output logic      [1:0]         sel_act,
  // measurement engine
  input  wire logic               meas_busy,
  input  wire logic               meas_done,
  input  wire logic signed [COUNT_W-1:0] meas_count,
  // stored word
  output logic      [15:0]        result
);
  if (COUNT_W < PMSR_CNT_BITS) begin : g_chk
    $error("pmsr_result_reg: COUNT_W too small");
  end

  // clamp to full scale and place above the padding
  function automatic logic [15:0] fmt(input logic signed [COUNT_W-1:0] c);
    logic signed [9:0] s;
    s = 10'sh000;
    if (c > COUNT_W'(PMSR_FS_POS)) s = PMSR_FS_POS;
    else if (c < COUNT_W'(PMSR_FS_NEG)) s = PMSR_FS_NEG;
    else s = c[9:0];
    fmt = {s, {PMSR_PAD_BITS{1'b0}}};
  endfunction

  // selection reaches the engine only between operations
  always_ff @(posedge clk) begin
    if (!rst_n) sel_act <= PMSR_SEL_POWER;
    else if (!meas_busy && !meas_done) sel_act <= sel_cfg;
  end

  // one register, whatever quantity is selected
  always_ff @(posedge clk) begin
    if (!rst_n) result <= PMSR_RES_RESET;
    else if (meas_done) result <= fmt(meas_count);
  end
endmodule // pmsr_result_reg

/* File: verification/pmsr_chk.sv */
/*
  pmsr_chk: port-level assertions for the serial readout.
  assumes: bound into pmsr_smbus_slave; open-drain data line, one core clock.
*/
`timescale 1ns/1ps
module pmsr_chk
  import pmsr_pkg::*;
#(
  parameter int COUNT_W = 10
)(
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // bus pins
  input wire logic                      scl_in,
  input wire logic                      sda_in,
  input wire logic                      sda_out,
  input wire logic                      sda_oe,
  // measurement side
  input wire logic                      meas_busy,
  input wire logic                      meas_done,
  input wire logic signed [COUNT_W-1:0] meas_count,
  input wire logic [1:0]                meas_sel,
  input wire logic [15:0]               cfg_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a driven bit lasts at least eight core cycles
  sequence s_oe_held; sda_oe [*8]; endsequence
  // engine neither measuring nor finishing
  sequence s_idle; !meas_busy && !meas_done; endsequence
  property p_pull_only; sda_out == 1'b0; endproperty
  a_pull_only: assert property (p_pull_only) else $error("data pin driven high");
  property p_rst;
    disable iff (1'b0) !rst_n |=> !sda_oe && cfg_word == PMSR_CFG_RESET && meas_sel == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_oe_hold; $rose(sda_oe) |-> s_oe_held; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("driven bit too short");
  property p_oe_edge; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data moved with clock high");
  property p_oe_scl_high; $rose(scl_in) |-> $stable(sda_oe) [*8]; endproperty
  a_oe_scl_high: assert property (p_oe_scl_high) else $error("data unstable");
  property p_cfg_edge; $changed(cfg_word) |-> !scl_in; endproperty
  a_cfg_edge: assert property (p_cfg_edge) else $error("config moved off frame");
  property p_sel_idle; $changed(meas_sel) |-> !$past(meas_busy, 2) && !$past(meas_done, 2);
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("selection moved mid run");
  property p_sel_val; $changed(meas_sel) |-> meas_sel == cfg_word[7:6]; endproperty
  a_sel_val: assert property (p_sel_val) else $error("selection not from config");
  property p_sel_lat; $changed(cfg_word) ##0 s_idle [*3] |-> meas_sel == cfg_word[7:6];
  endproperty
  a_sel_lat: assert property (p_sel_lat) else $error("selection not applied");
endmodule // pmsr_chk

bind pmsr_smbus_slave pmsr_chk #(.COUNT_W(COUNT_W)) u_chk (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .meas_busy(meas_busy), .meas_done(meas_done),
  .meas_count(meas_count), .meas_sel(meas_sel), .cfg_word(cfg_word));

/* File: verification/pmsr_host_model.sv */
/*
  pmsr_host_model: behavioural bus master facing the readout.
  assumes: the bench resolves the open-drain wire; clk is the time base.
*/
`timescale 1ns/1ps
module pmsr_host_model (
  // time base
  input  wire logic clk,
  // resolved data wire
  input  wire logic sda,
  // master drive
  output logic      scl,
  output logic      sda_low
);
  int half = 10;  // cycles per phase, never below 8
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // wait one phase
  task automatic ph();
    repeat (half) @(posedge clk);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_c();
    ph();
    sda_low <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    sda_low <= 1'b1;
    ph();
    scl <= 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop_c();
    ph();
    sda_low <= 1'b1;
    ph();
    scl <= 1'b1;
    ph();
    sda_low <= 1'b0;
    ph();
  endtask
  // data set with clock low, held over the high phase
  task automatic tx_bit(input logic b);
    ph();
    sda_low <= ~b;
    ph();
    scl <= 1'b1;
    ph();
    scl <= 1'b0;
  endtask
  // line released, sampled at end of high phase
  task automatic rx_bit(output logic b);
    ph();
    sda_low <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    b = sda;
    scl <= 1'b0;
  endtask
  // byte out msb first, ack bit back (0 = ack)
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) tx_bit(d[i]);
    rx_bit(ack);
  endtask
  // byte in msb first, then ack (0) or nack (1)
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rx_bit(d[i]);
    tx_bit(nack);
  endtask
endmodule // pmsr_host_model

/* File: verification/pmsr_smbus_slave_tb.sv */
/*
  pmsr_smbus_slave_tb: self-checking bench for the serial readout.
  assumes: host model drives the bus, bench plays the measurement engine.
*/
`timescale 1ns/1ps
module pmsr_smbus_slave_tb
  import pmsr_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h2a;  // arbitrary bus address
  // dut side
  logic              clk;
  logic              rst_n;
  logic              scl;
  logic              host_low;
  wire               sda_w;
  logic              sda_out;
  logic              sda_oe;
  logic              meas_busy;
  logic              meas_done;
  logic signed [9:0] meas_count;
  logic [1:0]        meas_sel;
  logic [15:0]       cfg_word;
  // bench state
  int                error_cnt = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  logic              a;
  logic [1:0]        prev;
  logic [15:0]       cfg_tab [4] = '{16'hfe40, 16'h8380, 16'h0001, 16'h0040};
  logic signed [9:0] cnt_tab [4] = '{10'sh100, -10'sh100, 10'sh000, -10'sh001};
  logic [7:0]        rd_cmd [3] = '{PMSR_CMD_VOUT, PMSR_CMD_IOUT, PMSR_CMD_POUT};
  // open-drain wire with pull-up
  assign sda_w = ~(host_low | (sda_oe & ~sda_out));
  pmsr_smbus_slave #(.SLAVE_ADDR(ADDR), .COUNT_W(10)) dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .meas_busy(meas_busy), .meas_done(meas_done),
    .meas_count(meas_count), .meas_sel(meas_sel), .cfg_word(cfg_word));
  pmsr_host_model host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(host_low));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // counts, verdict, stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // command then word, low byte first
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d);
    logic a0, a1, a2, a3;
    host.start_c();
    host.wr_byte({ADDR, 1'b0}, a0);
    host.wr_byte(cmd, a1);
    host.wr_byte(d[7:0], a2);
    host.wr_byte(d[15:8], a3);
    host.stop_c();
    chk("write acks", {12'h0, a0, a1, a2, a3}, 16'h0);
  endtask
  // combined format: command, repeated start, low then high byte
  task automatic rd_word(input logic [7:0] cmd, input logic [15:0] exp);
    logic a0, a1, a2;
    logic [7:0] lo, hi;
    host.start_c();
    host.wr_byte({ADDR, 1'b0}, a0);
    host.wr_byte(cmd, a1);
    host.start_c();
    host.wr_byte({ADDR, 1'b1}, a2);
    host.rd_byte(1'b0, lo);
    host.rd_byte(1'b1, hi);
    host.stop_c();
    chk("read acks", {13'h0, a0, a1, a2}, 16'h0);
    chk("read word", {hi, lo}, exp);
  endtask
  // one finished measurement
  task automatic measure(input logic signed [9:0] c);
    meas_done <= 1'b1;
    meas_count <= c;
    @(posedge clk);
    meas_done <= 1'b0;
    @(posedge clk);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    meas_busy = 1'b0;
    meas_done = 1'b0;
    meas_count = 10'sh000;
    prev = PMSR_SEL_POWER;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cfg after reset", cfg_word, PMSR_CFG_RESET);
    rd_word(PMSR_CMD_CFG, PMSR_CFG_RESET);
    // foreign address gets no ack
    host.start_c();
    host.wr_byte({ADDR ^ 7'h01, 1'b0}, a);
    host.stop_c();
    chk("foreign address", {15'h0, a}, 16'h0001);
    // each round: select while busy, release, measure, read all three ways
    for (int k = 0; k < 4; k++) begin
      host.half = 8 + 6 * k;
      meas_busy <= 1'b1;
      wr_word(PMSR_CMD_CFG, cfg_tab[k]);
      repeat (10) @(posedge clk);
      chk("sel while busy", {14'h0, meas_sel}, {14'h0, prev});
      meas_busy <= 1'b0;
      repeat (4) @(posedge clk);
      prev = cfg_tab[k][7:6];
      chk("sel applied", {14'h0, meas_sel}, {14'h0, prev});
      chk("cfg word", cfg_word, cfg_tab[k]);
      rd_word(PMSR_CMD_CFG, cfg_tab[k]);
      measure(cnt_tab[k]);
      for (int j = 0; j < 3; j++) begin
        rd_word(rd_cmd[j], {cnt_tab[k], 6'h00});
      end
    end
    host.half = 8;
    // beyond full scale reads full scale, both signs
    measure(10'sh1ff);
    rd_word(PMSR_CMD_POUT, 16'h4000);
    measure(-10'sh1ff);
    rd_word(PMSR_CMD_IOUT, 16'hc000);
    // an unknown code is acked but moves nothing and reads all ones
    wr_word(8'h01, 16'h01c0);
    repeat (4) @(posedge clk);
    chk("cfg kept", cfg_word, cfg_tab[3]);
    rd_word(8'h01, PMSR_NO_DATA);
    // with the engine idle a new selection is applied at once
    wr_word(PMSR_CMD_CFG, 16'h0080);
    repeat (4) @(posedge clk);
    chk("sel idle", {14'h0, meas_sel}, {14'h0, PMSR_SEL_CURR});
    // second reset in mid run brings back start-up values
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cfg after rerun", cfg_word, PMSR_CFG_RESET);
    chk("sel after rerun", {14'h0, meas_sel}, {14'h0, PMSR_SEL_POWER});
    rd_word(PMSR_CMD_VOUT, PMSR_RES_RESET);
    end_of_test();
  end
endmodule // pmsr_smbus_slave_tb
